/* core/aofs_core.sv */
// output registers, sample queue and event status of the accelerometer
`timescale 1ns/10ps
`include "aofs_defs.svh"

// What this block does
// - eight-bit read-only event status register
// - fill limit flag when count reaches limit
// - new sample flag once all axes fresh
// - orientation flag follows position change detection
// - wake and sleep flags follow their events
// - fall, single and double knock flags
// - axes as low then high byte, X Y Z
// - low bits zero, two more in lp1
// - mode field resets to bypass, queue off
// - mode 001 stores until full, then stops
// - mode 110 overwrites oldest when full
// - mode 011 streams until trigger drops
// - mode 100 bypasses until trigger drops
// - five-bit writable fill level limit
// - overwrite flag only when full and dropped
// - six-bit unread count, 32 means full
// - planar orientation enable bit
// - angle code decodes to 6/11/16/21 lsb
// - five-bit x knock threshold, low bits
module aofs_core #(
    parameter int DEPTH = `AOFS_FIFO_DEPTH,
    parameter int CNT_W = 6
) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic [7:0] reg_addr,
    input wire logic reg_wr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    input wire logic sample_valid,
    input aofs_pkg::aofs_axis_t sample_x,
    input aofs_pkg::aofs_axis_t sample_y,
    input aofs_pkg::aofs_axis_t sample_z,
    input wire logic lp_mode1,
    input wire logic queue_trigger,
    input wire logic wake_event,
    input wire logic sleep_event,
    input wire logic double_knock_event,
    input wire logic single_knock_event,
    input wire logic orientation_event,
    input wire logic fall_event,
    output logic planar_orientation_enable,
    output logic [1:0] orientation_angle_sel,
    output logic [4:0] orientation_angle_lsb,
    output logic [4:0] x_knock_threshold
);
    import aofs_pkg::*;

    localparam int WIDTH = 48;

    aofs_phase_t phase_reg;
    aofs_phase_t phase_next;
    logic [7:0] queue_config_reg;
    logic [7:0] orient_knock_reg;
    logic [7:0] rdata_reg;
    logic [7:0] rdata_next;
    logic [5:0] event_reg;
    logic new_sample_flag;
    logic overwrite_flag;
    logic [47:0] out_reg;
    logic [4:0] angle_lsb_reg;
    aofs_axis_t fmt_x;
    aofs_axis_t fmt_y;
    aofs_axis_t fmt_z;
    logic [WIDTH-1:0] fifo_head;
    logic [CNT_W-1:0] fifo_count;
    logic fifo_full;
    logic fifo_empty;
    logic fifo_dropped;
    logic fifo_push;
    logic fifo_pop;
    logic fifo_flush;
    logic fifo_overwrite;
    logic queue_active;
    logic fill_limit_reached_flag;
    logic mode_write;
    logic knock_write;
    logic axis_read;
    logic [2:0] queue_mode_sel;
    logic [4:0] fill_level_limit;

    assign queue_mode_sel =
        queue_config_reg[`AOFS_QC_MODE_MSB:`AOFS_QC_MODE_LSB];
    assign fill_level_limit =
        queue_config_reg[`AOFS_QC_LIMIT_MSB:`AOFS_QC_LIMIT_LSB];
    assign mode_write = reg_wr && (reg_addr == `AOFS_ADDR_QUEUE_CONFIG);
    assign knock_write = reg_wr && (reg_addr == `AOFS_ADDR_ORIENT_KNOCK);
    assign axis_read = reg_rd && (reg_addr >= `AOFS_ADDR_X_LOW)
        && (reg_addr <= `AOFS_ADDR_Z_HIGH);

    // one formatter per axis keeps the masking in one place
    aofs_axis_fmt #(
        .ZERO_BITS(`AOFS_AXIS_ZERO_BITS),
        .LP1_BITS(`AOFS_AXIS_LP1_BITS)
    ) u_fmt_x (
        .raw(sample_x),
        .lp_mode1(lp_mode1),
        .fmt(fmt_x)
    );

    aofs_axis_fmt #(
        .ZERO_BITS(`AOFS_AXIS_ZERO_BITS),
        .LP1_BITS(`AOFS_AXIS_LP1_BITS)
    ) u_fmt_y (
        .raw(sample_y),
        .lp_mode1(lp_mode1),
        .fmt(fmt_y)
    );

    aofs_axis_fmt #(
        .ZERO_BITS(`AOFS_AXIS_ZERO_BITS),
        .LP1_BITS(`AOFS_AXIS_LP1_BITS)
    ) u_fmt_z (
        .raw(sample_z),
        .lp_mode1(lp_mode1),
        .fmt(fmt_z)
    );

    // queue configuration, written by the host
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            queue_config_reg <= `AOFS_QUEUE_CONFIG_RST;
        end else if (mode_write) begin
            queue_config_reg <= reg_wdata;
        end
    end

    // orientation and knock settings
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            orient_knock_reg <= `AOFS_ORIENT_KNOCK_RST;
        end else if (knock_write) begin
            orient_knock_reg <= reg_wdata;
        end
    end

    // queue phase machine
    always_comb begin
        phase_next = phase_reg;
        if (mode_write) begin
            unique case (reg_wdata[`AOFS_QC_MODE_MSB:`AOFS_QC_MODE_LSB])
                `AOFS_MODE_STOP_FULL: phase_next = AOFS_PH_STOP;
                `AOFS_MODE_STREAM: phase_next = AOFS_PH_STREAM;
                `AOFS_MODE_STREAM_TO_STOP: phase_next = AOFS_PH_PRE_STREAM;
                `AOFS_MODE_BYPASS_TO_STOP: phase_next = AOFS_PH_WAIT;
                default: phase_next = AOFS_PH_OFF;
            endcase
        end else if (sample_valid && !queue_trigger) begin
            unique case (phase_reg)
                AOFS_PH_PRE_STREAM: phase_next = AOFS_PH_STOP;
                AOFS_PH_WAIT: phase_next = AOFS_PH_STOP;
                AOFS_PH_OFF,
                AOFS_PH_STOP,
                AOFS_PH_STREAM: phase_next = phase_reg;
            endcase
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            phase_reg <= AOFS_PH_OFF;
        end else begin
            phase_reg <= phase_next;
        end
    end

    assign queue_active = (phase_reg == AOFS_PH_STOP)
        || (phase_reg == AOFS_PH_STREAM)
        || (phase_reg == AOFS_PH_PRE_STREAM);
    assign fifo_overwrite = (phase_reg == AOFS_PH_STREAM)
        || (phase_reg == AOFS_PH_PRE_STREAM);
    assign fifo_push = sample_valid && queue_active;
    // a read of the last byte of a sample frees it
    assign fifo_pop = reg_rd && (reg_addr == `AOFS_ADDR_Z_HIGH)
        && queue_active;
    assign fifo_flush = (phase_reg == AOFS_PH_OFF)
        || (phase_reg == AOFS_PH_WAIT);

    aofs_sample_fifo #(
        .WIDTH(WIDTH),
        .DEPTH(DEPTH),
        .CNT_W(CNT_W)
    ) u_fifo (
        .ref_clk(ref_clk),
        .rst(rst),
        .flush(fifo_flush),
        .push(fifo_push),
        .overwrite_en(fifo_overwrite),
        .wdata({fmt_z, fmt_y, fmt_x}),
        .pop(fifo_pop),
        .head(fifo_head),
        .count(fifo_count),
        .full(fifo_full),
        .empty(fifo_empty),
        .dropped(fifo_dropped)
    );

    assign fill_limit_reached_flag =
        (fifo_count >= {1'b0, fill_level_limit});

    // output sample registers
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            out_reg <= '0;
        end else if (queue_active) begin
            // head may move under an unfinished read in overwrite mode
            if (!fifo_empty) begin
                out_reg <= fifo_head;
            end
        end else if (sample_valid) begin
            out_reg <= {fmt_z, fmt_y, fmt_x};
        end
    end

    // new sample flag: set by a complete sample, cleared by axis reads
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            new_sample_flag <= 1'b0;
        end else if (sample_valid) begin
            new_sample_flag <= 1'b1;
        end else if (axis_read) begin
            new_sample_flag <= 1'b0;
        end
    end

    // detection engine results, one sample per clock
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            event_reg <= '0;
        end else begin
            event_reg[5] <= wake_event;
            event_reg[4] <= sleep_event;
            event_reg[3] <= double_knock_event;
            event_reg[2] <= single_knock_event;
            event_reg[1] <= orientation_event;
            event_reg[0] <= fall_event;
        end
    end

    // overwrite flag: held while full, dropped once the queue is no longer full or is flushed
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            overwrite_flag <= 1'b0;
        end else if (fifo_dropped) begin
            overwrite_flag <= 1'b1;
        end else if (!fifo_full || fifo_flush) begin
            overwrite_flag <= 1'b0;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            angle_lsb_reg <= `AOFS_ANGLE_80;
        end else begin
            unique case (orient_knock_reg[`AOFS_OK_ANGLE_MSB:
                                          `AOFS_OK_ANGLE_LSB])
                2'h0: angle_lsb_reg <= `AOFS_ANGLE_80;
                2'h1: angle_lsb_reg <= `AOFS_ANGLE_70;
                2'h2: angle_lsb_reg <= `AOFS_ANGLE_60;
                2'h3: angle_lsb_reg <= `AOFS_ANGLE_50;
            endcase
        end
    end

    // read mux
    always_comb begin
        rdata_next = `AOFS_RDATA_RST;
        unique case (reg_addr)
            `AOFS_ADDR_EVENT_FLAGS: begin
                rdata_next[`AOFS_EV_FILL_LIMIT] = fill_limit_reached_flag;
                rdata_next[`AOFS_EV_WAKE] = event_reg[5];
                rdata_next[`AOFS_EV_SLEEP] = event_reg[4];
                rdata_next[`AOFS_EV_DTAP] = event_reg[3];
                rdata_next[`AOFS_EV_STAP] = event_reg[2];
                rdata_next[`AOFS_EV_ORIENT] = event_reg[1];
                rdata_next[`AOFS_EV_FALL] = event_reg[0];
                rdata_next[`AOFS_EV_NEW_SAMPLE] = new_sample_flag;
            end
            `AOFS_ADDR_X_LOW: rdata_next = out_reg[7:0];
            `AOFS_ADDR_X_HIGH: rdata_next = out_reg[15:8];
            `AOFS_ADDR_Y_LOW: rdata_next = out_reg[23:16];
            `AOFS_ADDR_Y_HIGH: rdata_next = out_reg[31:24];
            `AOFS_ADDR_Z_LOW: rdata_next = out_reg[39:32];
            `AOFS_ADDR_Z_HIGH: rdata_next = out_reg[47:40];
            `AOFS_ADDR_QUEUE_CONFIG: rdata_next = queue_config_reg;
            `AOFS_ADDR_QUEUE_FILL: begin
                rdata_next[`AOFS_QF_LIMIT_FLAG] = fill_limit_reached_flag;
                // flag clears a cycle after the first pop, so gate on full
                rdata_next[`AOFS_QF_OVERWRITE] = overwrite_flag && fifo_full;
                rdata_next[5:0] = 6'(fifo_count);
            end
            `AOFS_ADDR_ORIENT_KNOCK: rdata_next = orient_knock_reg;
            default: rdata_next = `AOFS_RDATA_RST;
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            rdata_reg <= `AOFS_RDATA_RST;
        end else if (reg_rd) begin
            rdata_reg <= rdata_next;
        end
    end

    assign reg_rdata = rdata_reg;
    assign planar_orientation_enable = orient_knock_reg[`AOFS_OK_PLANAR];
    assign orientation_angle_sel =
        orient_knock_reg[`AOFS_OK_ANGLE_MSB:`AOFS_OK_ANGLE_LSB];
    assign orientation_angle_lsb = angle_lsb_reg;
    assign x_knock_threshold =
        orient_knock_reg[`AOFS_OK_KNOCK_MSB:`AOFS_OK_KNOCK_LSB];
endmodule // aofs_core

/* core/aofs_defs.svh */
// register offsets, field positions, reset values and decode constants
`ifndef AOFS_DEFS_SVH
`define AOFS_DEFS_SVH

`define AOFS_ADDR_EVENT_FLAGS 8'h27
`define AOFS_ADDR_X_LOW 8'h28
`define AOFS_ADDR_X_HIGH 8'h29
`define AOFS_ADDR_Y_LOW 8'h2a
`define AOFS_ADDR_Y_HIGH 8'h2b
`define AOFS_ADDR_Z_LOW 8'h2c
`define AOFS_ADDR_Z_HIGH 8'h2d
`define AOFS_ADDR_QUEUE_CONFIG 8'h2e
`define AOFS_ADDR_QUEUE_FILL 8'h2f
`define AOFS_ADDR_ORIENT_KNOCK 8'h30

`define AOFS_EV_FILL_LIMIT 7
`define AOFS_EV_WAKE 6
`define AOFS_EV_SLEEP 5
`define AOFS_EV_DTAP 4
`define AOFS_EV_STAP 3
`define AOFS_EV_ORIENT 2
`define AOFS_EV_FALL 1
`define AOFS_EV_NEW_SAMPLE 0

`define AOFS_QC_MODE_MSB 7
`define AOFS_QC_MODE_LSB 5
`define AOFS_QC_LIMIT_MSB 4
`define AOFS_QC_LIMIT_LSB 0
`define AOFS_QF_LIMIT_FLAG 7
`define AOFS_QF_OVERWRITE 6
`define AOFS_OK_PLANAR 7
`define AOFS_OK_ANGLE_MSB 6
`define AOFS_OK_ANGLE_LSB 5
`define AOFS_OK_KNOCK_MSB 4
`define AOFS_OK_KNOCK_LSB 0

`define AOFS_QUEUE_CONFIG_RST 8'h00
`define AOFS_ORIENT_KNOCK_RST 8'h00
`define AOFS_RDATA_RST 8'h00

`define AOFS_MODE_BYPASS 3'h0
`define AOFS_MODE_STOP_FULL 3'h1
`define AOFS_MODE_STREAM_TO_STOP 3'h3
`define AOFS_MODE_BYPASS_TO_STOP 3'h4
`define AOFS_MODE_STREAM 3'h6

`define AOFS_ANGLE_80 5'h06
`define AOFS_ANGLE_70 5'h0b
`define AOFS_ANGLE_60 5'h10
`define AOFS_ANGLE_50 5'h15

`define AOFS_FIFO_DEPTH 32
`define AOFS_AXIS_ZERO_BITS 2
`define AOFS_AXIS_LP1_BITS 2

`endif

/* core/aofs_pkg.sv */
// types shared by the output, queue and status logic
package aofs_pkg;

    typedef enum logic [2:0] {
        AOFS_PH_OFF,
        AOFS_PH_STOP,
        AOFS_PH_STREAM,
        AOFS_PH_PRE_STREAM,
        AOFS_PH_WAIT
    } aofs_phase_t;

    typedef logic [15:0] aofs_axis_t;

endpackage

/* core/aofs_axis_fmt.sv */
// one axis sample with its low resolution bits forced to zero
`timescale 1ns/10ps
module aofs_axis_fmt #(
    parameter int ZERO_BITS = 2,
    parameter int LP1_BITS = 2
) (
    input aofs_pkg::aofs_axis_t raw,
    input wire logic lp_mode1,
    output aofs_pkg::aofs_axis_t fmt
);
    import aofs_pkg::*;

    localparam aofs_axis_t ALWAYS_MASK = aofs_axis_t'((1 << ZERO_BITS) - 1);
    localparam aofs_axis_t LP1_MASK =
        aofs_axis_t'(((1 << LP1_BITS) - 1) << ZERO_BITS);

    always_comb begin
        fmt = raw & ~ALWAYS_MASK;
        if (lp_mode1) begin
            fmt = fmt & ~LP1_MASK;
        end
    end
endmodule // aofs_axis_fmt

/* core/aofs_sample_fifo.sv */
// sample queue with optional overwrite of the oldest entry
`timescale 1ns/10ps
module aofs_sample_fifo #(
    parameter int WIDTH = 48,
    parameter int DEPTH = 32,
    parameter int CNT_W = 6
) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic flush,
    input wire logic push,
    input wire logic overwrite_en,
    input wire logic [WIDTH-1:0] wdata,
    input wire logic pop,
    output logic [WIDTH-1:0] head,
    output logic [CNT_W-1:0] count,
    output logic full,
    output logic empty,
    output logic dropped
);
    localparam int PTR_W = $clog2(DEPTH);
    localparam logic [PTR_W-1:0] LAST = PTR_W'(DEPTH - 1);
    localparam logic [CNT_W-1:0] FULL_CNT = CNT_W'(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [PTR_W-1:0] wr_ptr_reg;
    logic [PTR_W-1:0] rd_ptr_reg;
    logic [CNT_W-1:0] count_reg;
    logic do_pop;
    logic do_push;
    logic evict;

    assign full = (count_reg == FULL_CNT);
    assign empty = (count_reg == '0);
    assign do_pop = pop && !empty;
    // a full queue only takes a sample when a pop frees a slot in the same cycle or it may drop the oldest
    assign do_push = push && (!full || do_pop || overwrite_en);
    assign evict = push && full && !do_pop && overwrite_en;
    assign dropped = evict;
    assign head = mem[rd_ptr_reg];
    assign count = count_reg;

    always_ff @(posedge ref_clk) begin
        if (do_push) begin
            mem[wr_ptr_reg] <= wdata;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst || flush) begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
            count_reg <= '0;
        end else begin
            if (do_push) begin
                wr_ptr_reg <= (wr_ptr_reg == LAST) ? '0 : wr_ptr_reg + 1'b1;
            end
            if (do_pop || evict) begin
                rd_ptr_reg <= (rd_ptr_reg == LAST) ? '0 : rd_ptr_reg + 1'b1;
            end
            if (do_push && !do_pop && !evict) begin
                count_reg <= count_reg + 1'b1;
            end else if (do_pop && !do_push) begin
                count_reg <= count_reg - 1'b1;
            end
        end
    end
endmodule // aofs_sample_fifo

/* verification/aofs_core_props.sv */
// concurrent checks on the register side of the read-out block
`timescale 1ns/10ps
module aofs_core_props #(
    parameter int DEPTH = 32
) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic [7:0] reg_addr,
    input wire logic reg_wr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_rd,
    input wire logic [7:0] reg_rdata,
    input wire logic wake_event,
    input wire logic sleep_event,
    input wire logic double_knock_event,
    input wire logic single_knock_event,
    input wire logic orientation_event,
    input wire logic fall_event,
    input wire logic planar_orientation_enable,
    input wire logic [1:0] orientation_angle_sel,
    input wire logic [4:0] orientation_angle_lsb,
    input wire logic [4:0] x_knock_threshold
);
    // events packed in status bit order 6..1
    wire logic [5:0] ev_now = {wake_event, sleep_event, double_knock_event,
        single_knock_event, orientation_event, fall_event};
    default clocking @(posedge ref_clk);
    endclocking
    default disable iff (rst);
    a_rdata_hold: assert property (!$past(reg_rd) |-> $stable(reg_rdata))
        else $error("read data moved without a read");
    a_unmapped_zero: assert property (reg_rd &&
        (reg_addr < 8'h27 || reg_addr > 8'h30) |=> reg_rdata == 8'h00)
        else $error("unmapped read not zero");
    a_low_bits_zero: assert property (reg_rd &&
        reg_addr inside {8'h28, 8'h2a, 8'h2c} |=> reg_rdata[1:0] == 2'h0)
        else $error("axis low byte bits 1:0 not zero");
    a_angle_decode: assert property (orientation_angle_lsb ==
        5'h06 + 5'h05 * {3'h0, $past(orientation_angle_sel)})
        else $error("angle decode wrong");
    a_cfg_fields: assert property (reg_wr && reg_addr == 8'h30 |=>
        {planar_orientation_enable, orientation_angle_sel,
        x_knock_threshold} == $past(reg_wdata))
        else $error("orientation fields not written");
    a_status_mirror: assert property (reg_rd && reg_addr == 8'h27 |=>
        reg_rdata[6:1] == $past(ev_now, 2))
        else $error("event flags do not follow events");
    a_count_bound: assert property (reg_rd && reg_addr == 8'h2f |=>
        int'(reg_rdata[5:0]) <= DEPTH)
        else $error("unread count above depth");
    a_overwrite_full: assert property (reg_rd && reg_addr == 8'h2f |=>
        !reg_rdata[6] || int'(reg_rdata[5:0]) == DEPTH)
        else $error("overwrite flag while not full");
endmodule // aofs_core_props

bind aofs_core aofs_core_props #(.DEPTH(DEPTH)) i_aofs_core_props (
    .ref_clk, .rst, .reg_addr, .reg_wr, .reg_wdata, .reg_rd, .reg_rdata,
    .wake_event, .sleep_event, .double_knock_event, .single_knock_event,
    .orientation_event, .fall_event, .planar_orientation_enable,
    .orientation_angle_sel, .orientation_angle_lsb, .x_knock_threshold
);

/* verification/aofs_host_model.sv */
// host side of the register port: strobed reads and writes
`timescale 1ns/10ps
module aofs_host_model (
    input wire logic ref_clk,
    output logic [7:0] reg_addr,
    output logic reg_wr,
    output logic [7:0] reg_wdata,
    output logic reg_rd,
    input wire logic [7:0] reg_rdata
);
    initial begin
        reg_addr = 8'h00;
        reg_wr = 1'b0;
        reg_wdata = 8'h00;
        reg_rd = 1'b0;
    end
    task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
        if (a == 8'h2e && d[7:5] inside {3'h2, 3'h5, 3'h7}) begin
            return;
        end
        @(negedge ref_clk);
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        @(negedge ref_clk);
        reg_wr = 1'b0;
        // released data flips so a stale value never looks valid
        reg_wdata = ~d;
    endtask
    task automatic read_reg(input logic [7:0] a, output logic [7:0] d);
        @(negedge ref_clk);
        reg_addr = a;
        reg_rd = 1'b1;
        @(negedge ref_clk);
        reg_rd = 1'b0;
        d = reg_rdata;
    endtask
endmodule // aofs_host_model

/* verification/aofs_core_test.sv */
// self-checking bench for the accelerometer read-out block
`timescale 1ns/10ps
module aofs_core_test;
    logic ref_clk;
    logic rst;
    wire [7:0] reg_addr;
    wire reg_wr;
    wire [7:0] reg_wdata;
    wire reg_rd;
    logic [7:0] reg_rdata;
    logic sample_valid;
    aofs_pkg::aofs_axis_t sample_x;
    aofs_pkg::aofs_axis_t sample_y;
    aofs_pkg::aofs_axis_t sample_z;
    logic lp_mode1;
    logic queue_trigger;
    logic [5:0] ev;
    logic planar_orientation_enable;
    logic [1:0] orientation_angle_sel;
    logic [4:0] orientation_angle_lsb;
    logic [4:0] x_knock_threshold;
    int n_mismatch = 0;
    int n_tests = 0;
    int n_cycles = 0;

    aofs_core i_aofs_core (
        .ref_clk, .rst, .reg_addr, .reg_wr, .reg_wdata, .reg_rd, .reg_rdata,
        .sample_valid, .sample_x, .sample_y, .sample_z, .lp_mode1,
        .queue_trigger, .wake_event(ev[5]), .sleep_event(ev[4]),
        .double_knock_event(ev[3]), .single_knock_event(ev[2]),
        .orientation_event(ev[1]), .fall_event(ev[0]),
        .planar_orientation_enable, .orientation_angle_sel,
        .orientation_angle_lsb, .x_knock_threshold
    );
    aofs_host_model i_aofs_host_model (
        .ref_clk, .reg_addr, .reg_wr, .reg_wdata, .reg_rd, .reg_rdata
    );

    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end

    task automatic report_and_stop;
        $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    // a hang costs a mismatch, the run needs well under a thousand cycles
    always @(posedge ref_clk) begin
        n_cycles <= n_cycles + 1;
        if (n_cycles == 6000) begin
            n_mismatch++;
            report_and_stop();
        end
    end

    task automatic check(input string what, input logic [7:0] seen,
        input logic [7:0] exp);
        n_tests++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic rd_chk(input string what, input logic [7:0] a,
        input logic [7:0] exp);
        logic [7:0] d;
        i_aofs_host_model.read_reg(a, d);
        check(what, d, exp);
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        i_aofs_host_model.write_reg(a, d);
    endtask
    // high byte of x carries the sample number, so order shows at 0x29
    task automatic fill(input int from, input int n);
        for (int k = from; k < from + n; k++) begin
            @(negedge ref_clk);
            sample_valid = 1'b1;
            sample_x = {k[7:0], 8'h37};
            sample_y = {~k[7:0], 8'h5b};
            sample_z = {k[7:0] ^ 8'h3c, 8'hff};
            @(negedge ref_clk);
            sample_valid = 1'b0;
        end
    endtask

    initial begin
        rst = 1'b1;
        sample_valid = 1'b0;
        sample_x = 16'h0000;
        sample_y = 16'h0000;
        sample_z = 16'h0000;
        lp_mode1 = 1'b0;
        queue_trigger = 1'b0;
        ev = 6'h00;
        repeat (5) @(negedge ref_clk);
        rst = 1'b0;
        rd_chk("queue cfg", 8'h2e, 8'h00);
        rd_chk("orient cfg", 8'h30, 8'h00);
        check("angle", {3'h0, orientation_angle_lsb}, 8'h06);
        check("planar", {7'h0, planar_orientation_enable}, 8'h00);
        // a zero limit would hold the fill flag high, so use one
        wr(8'h2e, 8'h01);
        rd_chk("status", 8'h27, 8'h00);
        for (int i = 0; i < 4; i++) begin
            wr(8'h30, {1'b1, i[1:0], 5'h15});
            rd_chk("orient cfg", 8'h30, {1'b1, i[1:0], 5'h15});
            check("angle", {3'h0, orientation_angle_lsb},
                8'h06 + 8'h05 * i[7:0]);
            check("angle sel", {6'h0, orientation_angle_sel},
                {6'h0, i[1:0]});
            check("knock", {3'h0, x_knock_threshold}, 8'h15);
        end
        check("planar", {7'h0, planar_orientation_enable}, 8'h01);
        wr(8'h27, 8'hff);
        wr(8'h2f, 8'hff);
        rd_chk("status", 8'h27, 8'h00);
        rd_chk("fill", 8'h2f, 8'h00);
        rd_chk("unmapped", 8'h40, 8'h00);
        for (int i = 1; i < 7; i++) begin
            @(negedge ref_clk);
            ev = 6'h01 << (i - 1);
            rd_chk("event", 8'h27, 8'h01 << i);
            ev = 6'h00;
        end
        fill(8'h12, 1);
        rd_chk("status", 8'h27, 8'h01);
        rd_chk("x low", 8'h28, 8'h34);
        rd_chk("x high", 8'h29, 8'h12);
        rd_chk("y low", 8'h2a, 8'h58);
        rd_chk("y high", 8'h2b, 8'hed);
        rd_chk("z low", 8'h2c, 8'hfc);
        rd_chk("z high", 8'h2d, 8'h2e);
        rd_chk("status", 8'h27, 8'h00);
        lp_mode1 = 1'b1;
        fill(8'h12, 1);
        rd_chk("x low lp1", 8'h28, 8'h30);
        rd_chk("z low lp1", 8'h2c, 8'hf0);
        lp_mode1 = 1'b0;
        // stop when full, limit 5
        wr(8'h2e, 8'h25);
        fill(0, 4);
        rd_chk("fill", 8'h2f, 8'h04);
        fill(4, 1);
        rd_chk("status", 8'h27, 8'h81);
        fill(5, 28);
        rd_chk("fill", 8'h2f, 8'ha0);
        rd_chk("head", 8'h29, 8'h00);
        rd_chk("pop z", 8'h2d, 8'h3c);
        rd_chk("fill", 8'h2f, 8'h9f);
        rd_chk("head", 8'h29, 8'h01);
        // overwrite oldest
        wr(8'h2e, 8'h00);
        wr(8'h2e, 8'hc0);
        fill(0, 33);
        rd_chk("fill", 8'h2f, 8'he0);
        rd_chk("head", 8'h29, 8'h01);
        rd_chk("pop z", 8'h2d, 8'h3d);
        rd_chk("fill", 8'h2f, 8'h9f);
        rd_chk("head", 8'h29, 8'h02);
        // bypass until trigger drops
        wr(8'h2e, 8'h00);
        queue_trigger = 1'b1;
        wr(8'h2e, 8'h80);
        fill(0, 3);
        rd_chk("fill", 8'h2f, 8'h80);
        queue_trigger = 1'b0;
        fill(3, 3);
        rd_chk("fill", 8'h2f, 8'h82);
        rd_chk("head", 8'h29, 8'h04);
        // stream until trigger drops
        wr(8'h2e, 8'h00);
        queue_trigger = 1'b1;
        wr(8'h2e, 8'h60);
        fill(0, 33);
        rd_chk("fill", 8'h2f, 8'he0);
        queue_trigger = 1'b0;
        fill(33, 2);
        rd_chk("fill", 8'h2f, 8'he0);
        rd_chk("head", 8'h29, 8'h02);
        report_and_stop();
    end
endmodule // aofs_core_test
